// [hdl/wdt_defines.svh]
// constants for the watchdog timer with timed disable
// assumes inclusion by bare name from the design and bench files
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// ==========================================================================
// register map
// ==========================================================================
// printed offset is a register index, byte address is four times it
`define WDT_CTRL_IDX 8'h21
`define WDT_CTRL_ADDR (4 * `WDT_CTRL_IDX)
`define WDT_CTRL_RST 8'h00

// ==========================================================================
// control register fields
// ==========================================================================
`define WDT_PER_LSB 0
`define WDT_PER_MSB 2
`define WDT_ON_BIT 3
`define WDT_TOE_BIT 4
`define WDT_RSVD_LSB 5
`define WDT_RSVD_MSB 7

// ==========================================================================
// timing
// ==========================================================================
// nominal watchdog oscillator rate in hertz
`define WDT_OSC_HZ 1000000
// oscillator cycles of the shortest period
`define WDT_BASE_CYC 16384
// system clock cycles the turn-off window stays open
`define WDT_TOE_CYC 3'h4
// system clock cycles the reset request is held
`define WDT_SYSRST_CYC 3'h4

`endif

// [hdl/wdt_pkg.sv]
// types shared by the watchdog timer design
// assumes wdt_defines.svh holds every number but the response code values given here
package wdt_pkg;

  // ========================================================================
  // types
  // ========================================================================
  // period select code, 0 is the shortest period
  typedef logic [2:0] wdt_period_t;

  // axi write and read response codes
  typedef enum logic [1:0] {
    WDT_OKAY = 2'h0,
    WDT_SLVERR = 2'h2
  } wdt_resp_e;

endpackage : wdt_pkg

// [hdl/wdt_sync.sv]
// two flip-flop level synchroniser, one bit or a bundle of bits
// assumes each bit is held long enough to be seen on the destination clock
`timescale 1ns/10ps

module wdt_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // ========================================================================
  // synchroniser stages
  // ========================================================================
  logic [WIDTH-1:0] meta_q;

  // first stage read only by the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : wdt_sync

// [hdl/wdt_top.sv]
// watchdog timer with timed disable, control register over axi4-lite
// assumes aclk from the system, osc_clk from the free running watchdog
// oscillator, and a one-cycle restart strobe from the core on aclk
`timescale 1ns/10ps
`include "wdt_defines.svh"

module wdt_top #(
  parameter int ADDR_W = 12,
  parameter int CNT_W = 21,
  parameter int BASE_CYC = `WDT_BASE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic osc_clk,
  input wire logic restart_instr,
  output logic wdt_sysrst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ========================================================================
  // functions
  // ========================================================================
  // true when a byte address selects the control register
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == ADDR_W'(`WDT_CTRL_ADDR));
  endfunction : addr_hit
  // timeout length in oscillator cycles for a period code
  function automatic logic [CNT_W:0] period_len(input wdt_pkg::wdt_period_t sel);
    period_len = (CNT_W + 1)'(BASE_CYC) << sel;
  endfunction : period_len

  // ========================================================================
  // axi4-lite write channel
  // ========================================================================
  logic awready_q, wready_q, bvalid_q, aw_got_q, w_got_q;
  logic [1:0] bresp_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  wire aw_hs, w_hs, aw_have, w_have, wr_fire, aw_got_d, w_got_d, bvalid_d, wr_hit, wr_ctrl;
  wire [ADDR_W-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  // handshakes and the moment both halves of a write are present
  assign aw_hs = s_axi_awvalid & awready_q;
  assign w_hs = s_axi_wvalid & wready_q;
  assign aw_have = aw_got_q | aw_hs;
  assign w_have = w_got_q | w_hs;
  assign wr_fire = aw_have & w_have;
  assign aw_got_d = aw_have & ~wr_fire;
  assign w_got_d = w_have & ~wr_fire;
  assign bvalid_d = wr_fire | (bvalid_q & ~s_axi_bready);

  // address and data from the holding register or straight off the bus
  assign wr_addr = aw_got_q ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_got_q ? wdata_q : s_axi_wdata;
  assign wr_strb = w_got_q ? wstrb_q : s_axi_wstrb;
  assign wr_hit = addr_hit(wr_addr);
  // only byte lane 0 carries the register
  assign wr_ctrl = wr_fire & wr_hit & wr_strb[0];

  // write channel state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= wdt_pkg::WDT_OKAY;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      bvalid_q <= bvalid_d;
      awready_q <= ~aw_got_d & ~bvalid_d;
      wready_q <= ~w_got_d & ~bvalid_d;
      if (wr_fire) begin
        bresp_q <= wr_hit ? wdt_pkg::WDT_OKAY : wdt_pkg::WDT_SLVERR;
      end
    end
  end

  // holding registers for a half that arrives first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_hs) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // ========================================================================
  // control register
  // ========================================================================
  logic on_q, toe_q;
  logic [2:0] toe_cnt_q;
  wdt_pkg::wdt_period_t period_q;
  wire wr_on, wr_toe, toe_expire;
  wire [7:0] ctrl_rd;
  assign wr_on = wr_data[`WDT_ON_BIT];
  assign wr_toe = wr_data[`WDT_TOE_BIT];
  assign toe_expire = toe_q & (toe_cnt_q == 3'h1);
  // reserved bits read zero
  assign ctrl_rd = {3'h0, toe_q, on_q, period_q};

  // enable bit: set freely, cleared only inside the turn-off window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_q <= 1'(`WDT_CTRL_RST >> `WDT_ON_BIT);
    end else if (wr_ctrl) begin
      if (wr_on) begin
        on_q <= 1'b1;
      end else if (toe_q) begin
        on_q <= 1'b0;
      end
      // clear refused, watchdog keeps running
    end
  end

  // turn-off enable with its four-cycle self clear; a write wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      toe_q <= 1'b0;
      toe_cnt_q <= 3'h0;
    end else if (wr_ctrl) begin
      toe_q <= wr_toe;
      toe_cnt_q <= wr_toe ? `WDT_TOE_CYC : 3'h0;
    end else if (toe_expire) begin
      toe_q <= 1'b0;
      toe_cnt_q <= 3'h0;
    end else if (toe_q) begin
      toe_cnt_q <= toe_cnt_q - 3'h1;
    end
  end

  // period field, stored always, used only while enabled; reserved bits dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_q <= wdt_pkg::wdt_period_t'(`WDT_CTRL_RST);
    end else if (wr_ctrl) begin
      period_q <= wr_data[`WDT_PER_MSB:`WDT_PER_LSB];
    end
  end

  // ========================================================================
  // axi4-lite read channel
  // ========================================================================
  logic arready_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  wire ar_hs, rvalid_d, rd_hit;
  assign ar_hs = s_axi_arvalid & arready_q;
  assign rvalid_d = ar_hs | (rvalid_q & ~s_axi_rready);
  assign rd_hit = addr_hit(s_axi_araddr);

  // one read at a time, data captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= wdt_pkg::WDT_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      arready_q <= ~rvalid_d;
      if (ar_hs) begin
        rdata_q <= rd_hit ? {24'h00_0000, ctrl_rd} : 32'h0000_0000;
        rresp_q <= rd_hit ? wdt_pkg::WDT_OKAY : wdt_pkg::WDT_SLVERR;
      end
    end
  end

  // ========================================================================
  // system clock side of the crossing
  // ========================================================================
  logic restart_tgl_q, exp_prev_q, sysrst_q, exp_tgl_q;
  logic [2:0] sysrst_cnt_q;
  wire exp_tgl_s, exp_pulse;

  // each restart instruction flips the toggle, never missed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      restart_tgl_q <= 1'b0;
    end else if (restart_instr) begin
      restart_tgl_q <= ~restart_tgl_q;
    end
  end

  // expiry toggle from the oscillator domain
  wdt_sync #(.WIDTH(1)) u_sync_exp (
    .clk(aclk), .rst_n(aresetn),
    .d(exp_tgl_q), .q(exp_tgl_s)
  );
  assign exp_pulse = exp_tgl_s ^ exp_prev_q;

  // reset request held for a few system clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exp_prev_q <= 1'b0;
      sysrst_q <= 1'b0;
      sysrst_cnt_q <= 3'h0;
    end else begin
      exp_prev_q <= exp_tgl_s;
      if (exp_pulse) begin
        sysrst_q <= 1'b1;
        sysrst_cnt_q <= `WDT_SYSRST_CYC;
      end else if (sysrst_cnt_q == 3'h1) begin
        sysrst_q <= 1'b0;
        sysrst_cnt_q <= 3'h0;
      end else if (sysrst_q) begin
        sysrst_cnt_q <= sysrst_cnt_q - 3'h1;
      end
    end
  end

  // ========================================================================
  // oscillator side of the crossing
  // ========================================================================
  wire osc_rst_n, restart_s;
  wire [3:0] cfg_s;

  // system reset brought onto the oscillator clock
  wdt_sync #(.WIDTH(1)) u_sync_rst (
    .clk(osc_clk), .rst_n(1'b1),
    .d(aresetn), .q(osc_rst_n)
  );
  // restart toggle into the oscillator domain
  wdt_sync #(.WIDTH(1)) u_sync_restart (
    .clk(osc_clk), .rst_n(osc_rst_n),
    .d(restart_tgl_q), .q(restart_s)
  );
  // enable and period as slow levels; taken only once two samples agree
  wdt_sync #(.WIDTH(4)) u_sync_cfg (
    .clk(osc_clk), .rst_n(osc_rst_n),
    .d({on_q, period_q}), .q(cfg_s)
  );

  // ========================================================================
  // watchdog counter on the oscillator clock
  // ========================================================================
  logic restart_prev_q, osc_on_q;
  logic [3:0] cfg_prev_q;
  wdt_pkg::wdt_period_t osc_period_q;
  logic [CNT_W-1:0] cnt_q;
  wire restart_pulse, at_limit;
  wire [CNT_W:0] limit;
  assign restart_pulse = restart_s ^ restart_prev_q;
  assign limit = period_len(osc_period_q);
  assign at_limit = ({1'b0, cnt_q} >= (limit - (CNT_W + 1)'(1)));

  // stable configuration capture
  always_ff @(posedge osc_clk) begin
    if (!osc_rst_n) begin
      restart_prev_q <= 1'b0;
      cfg_prev_q <= 4'h0;
      osc_on_q <= 1'b0;
      osc_period_q <= 3'h0;
    end else begin
      restart_prev_q <= restart_s;
      cfg_prev_q <= cfg_s;
      if (cfg_s == cfg_prev_q) begin
        osc_on_q <= cfg_s[3];
        osc_period_q <= cfg_s[2:0];
      end
    end
  end

  // count oscillator cycles, clear on restart, toggle out on expiry
  always_ff @(posedge osc_clk) begin
    if (!osc_rst_n) begin
      cnt_q <= '0;
      exp_tgl_q <= 1'b0;
    end else if (!osc_on_q || restart_pulse) begin
      cnt_q <= '0;
    end else if (at_limit) begin
      cnt_q <= '0;
      exp_tgl_q <= ~exp_tgl_q;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // ========================================================================
  // outputs
  // ========================================================================
  assign wdt_sysrst = sysrst_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule : wdt_top

// [bench/wdt_monitor.sv]
// assertion monitor for the watchdog register port and reset request
// assumes binding into wdt_top, one aclk domain
`timescale 1ns/10ps
`include "wdt_defines.svh"

module wdt_monitor #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wdt_sysrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ==========================================================================
  // helpers
  // ==========================================================================
  // remembers whether the accepted read hit the control register
  logic hit_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_q <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      hit_q <= (s_axi_araddr == ADDR_W'(`WDT_CTRL_ADDR));
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // assertions
  // ==========================================================================
  property p_rst_len;
    $rose(wdt_sysrst) |-> wdt_sysrst [*4] ##1 !wdt_sysrst;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset request length wrong");
  property p_b_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_b_ans: assert property (p_b_ans) else $error("write answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer changed");
  property p_rsvd;
    s_axi_rvalid |-> s_axi_rdata[31:5] == 27'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_rmiss;
    s_axi_rvalid && !hit_q |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_rmiss: assert property (p_rmiss) else $error("unmapped read answer wrong");
  property p_rhit;
    s_axi_rvalid && hit_q |-> s_axi_rresp == 2'h0;
  endproperty
  a_rhit: assert property (p_rhit) else $error("control read refused");
endmodule : wdt_monitor

bind wdt_top wdt_monitor #(.ADDR_W(ADDR_W)) mon_u (
  .aclk(aclk), .aresetn(aresetn), .wdt_sysrst(wdt_sysrst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// [bench/wdt_core_model.sv]
// processor core model issuing the restart instruction
// assumes the bench raises kick for one cycle per instruction
`timescale 1ns/10ps

module wdt_core_model (
  input wire logic aclk,
  input wire logic kick,
  output logic restart_instr
);
  // one restart strobe per executed instruction
  always @(posedge aclk) begin
    restart_instr <= kick;
  end
endmodule : wdt_core_model

// [bench/test_watchdog_timer_with_timed_disable.sv]
// self-checking bench for the watchdog timer with timed disable
// assumes wdt_top with the bound monitor and the core model
`timescale 1ns/10ps
`include "wdt_defines.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end

module test_watchdog_timer_with_timed_disable;
  localparam int AW = 12;
  localparam logic [AW-1:0] CA = AW'(`WDT_CTRL_ADDR);
  logic aclk, aresetn, osc_clk, kick, restart_instr, wdt_sysrst;
  logic [AW-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] rv, d;
  logic [3:0] wstrb;
  int error_cnt, check_count, n, m, rst_seen;

  // ==========================================================================
  // clocks, partner and design
  // ==========================================================================
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // watchdog oscillator, own rate and phase
  initial begin
    osc_clk = 1'b0;
    #2;
    forever #11.5 osc_clk = ~osc_clk;
  end
  initial rst_seen = 0;
  always @(posedge wdt_sysrst) rst_seen++;

  wdt_core_model core_u (.aclk(aclk), .kick(kick), .restart_instr(restart_instr));
  wdt_top #(.ADDR_W(AW), .BASE_CYC(16)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .osc_clk(osc_clk), .restart_instr(restart_instr),
    .wdt_sysrst(wdt_sysrst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task automatic tmo();
    error_cnt++;
    end_sim();
  endtask : tmo

  task automatic wr(input logic [AW-1:0] a, input logic [7:0] v, input logic [1:0] er);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 60; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (k == 60) tmo();
    `CHK(bresp, er)
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, output logic [7:0] v, input logic [1:0] er);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 60; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (k == 60) tmo();
    `CHK(rresp, er)
    `CHK(rdata[31:8], 24'h0)
    v = rdata[7:0];
  endtask : rd

  task automatic rdchk(input logic [7:0] e);
    rd(CA, rv, 2'h0);
    `CHK(rv, e)
  endtask : rdchk

  // enable with period p, count oscillator cycles up to the reset request
  task automatic per_len(input int p);
    int k;
    int lim;
    lim = 16 << p;
    repeat (8) @(posedge aclk);
    wr(CA, 8'h08 | 8'(p), 2'h0);
    for (k = 0; k < lim + 40 && wdt_sysrst !== 1'b1; k++) @(posedge osc_clk);
    `CHK(k >= lim - 2 && k <= lim + 12, 1'b1)
    wr(CA, 8'h18 | 8'(p), 2'h0);
    wr(CA, 8'(p), 2'h0);
  endtask : per_len

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    aresetn = 1'b0;
    kick = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    n = $urandom(68616);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(8'h00);
    wr(12'h080, 8'h0F, wdt_pkg::WDT_SLVERR);
    rd(12'h088, rv, wdt_pkg::WDT_SLVERR);
    `CHK(rv, 8'h00)
    rdchk(8'h00);
    $display("done: reset and map");
    wr(CA, 8'hEF, 2'h0);
    rdchk(8'h0F);
    repeat (6) begin
      d = (8'($urandom) & 8'hE7) | 8'h08;
      wr(CA, d, 2'h0);
      rdchk(d & 8'h0F);
    end
    wr(CA, 8'h00, 2'h0);
    rdchk(8'h08);
    // byte lane 0 strobe low: write answered but ignored
    wstrb <= 4'hE;
    wr(CA, 8'h0F, 2'h0);
    wstrb <= 4'hF;
    rdchk(8'h08);
    wr(CA, 8'h1A, 2'h0);
    rdchk(8'h1A);
    repeat (6) @(posedge aclk);
    wr(CA, 8'h02, 2'h0);
    rdchk(8'h0A);
    wr(CA, 8'h1A, 2'h0);
    wr(CA, 8'h02, 2'h0);
    rdchk(8'h02);
    $display("done: control register");
    for (int p = 0; p < 8; p++) per_len(p);
    $display("done: periods");
    wr(CA, 8'h09, 2'h0);
    m = rst_seen;
    repeat (40) begin
      repeat ($urandom_range(14, 5)) @(posedge aclk);
      kick <= 1'b1;
      @(posedge aclk);
      kick <= 1'b0;
    end
    `CHK(rst_seen, m)
    for (n = 0; n < 52 && rst_seen == m; n++) @(posedge osc_clk);
    `CHK(rst_seen, m + 1)
    $display("done: restart");
    wr(CA, 8'h19, 2'h0);
    wr(CA, 8'h01, 2'h0);
    m = rst_seen;
    repeat (200) @(posedge osc_clk);
    `CHK(rst_seen, m)
    $display("done: disabled");
    end_sim();
  end
endmodule : test_watchdog_timer_with_timed_disable
